// ---- ocl_host.sv ----
// host-side register master that drives the block's register strobes
// assumes the caller steps it just after a rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module ocl_host
  import ocl_pkg::*;
(
  input  wire logic          clk,
  output var  logic [AW-1:0] reg_addr,
  output var  logic          reg_wr,
  output var  logic          reg_rd,
  output var  logic [DW-1:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // one strobe cycle per access; released lines show the inverse so stale values never pass
  task automatic access(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // write then read the same register on the very next edge, the read strobe rising in the same step the write strobe drops
  task automatic wr_rd(input logic [AW-1:0] a, input logic [DW-1:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    reg_rd = 1'b0;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_wdata = ~d;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule
`default_nettype wire

// ---- ocl_pkg.sv ----
// constants, register map and field layout of the overcurrent limit and sum compare block
// assumes a 16-bit register port fed by the serial interface logic on the same clock
// Summary of operation
// - each single conversion checked against critical limit
// - averaged value checked against warning limit
// - limit value in bits 15:3, 2:0 reserved
// - host reads and writes every limit field
// - limits reset to largest positive value 7ff8
// - sum adds only selected channels' single conversions
// - sum updated after each complete channel cycle
// - sum least significant bit weighs 40 uV
// - sum: sign 15, data 14:1, bit0 zero
// - sign one means negative two's complement
// - sum reads zero after reset
// - sum compared with sum limit each cycle
// - sum limit: sign, 14:1 data, 40 uV
// - sum limit resets to 7ffe
// - select bits only steer summation
// - critical excess sets flag and critical alert
// - sum excess sets flag and critical alert
// - flags clear on mask read, not write
package ocl_pkg;
  localparam int          NCH          = 3;
  localparam int          AW           = 8;
  localparam int          DW           = 16;
  localparam int          LIM_W        = 13;
  localparam int          TOT_W        = 15;
  localparam int          LIM_MSB      = 15;
  localparam int          LIM_LSB      = 3;
  localparam int          TOT_MSB      = 15;
  localparam int          TOT_LSB      = 1;
  localparam int          SEL_LSB      = 12;
  localparam int          CF_LSB       = 7;
  localparam int          SF_BIT       = 6;
  localparam int          WF_LSB       = 3;
  localparam int          LSB_UV       = 40;
  localparam logic [AW-1:0] ADDR_CRIT [NCH] = '{8'h07, 8'h09, 8'h0b};
  localparam logic [AW-1:0] ADDR_WARN [NCH] = '{8'h08, 8'h0a, 8'h0c};
  localparam logic [AW-1:0] ADDR_TOTAL   = 8'h0d;
  localparam logic [AW-1:0] ADDR_TLIM    = 8'h0e;
  localparam logic [AW-1:0] ADDR_MASK    = 8'h0f;
  localparam logic [DW-1:0] LIM_RST      = 16'h7ff8;
  localparam logic [DW-1:0] TLIM_RST     = 16'h7ffe;
  localparam logic [TOT_W-1:0] TOT_RST   = 15'h0000;
  localparam logic [NCH-1:0] FLG_RST     = 3'h0;
  localparam logic [DW-1:0] ZERO_W       = 16'h0000;
  localparam logic [1:0]    CH_NONE      = 2'h3;
endpackage

// ---- ocl_top.sv ----
// limit registers, shunt sum and alert flags of a three-channel current monitor
// assumes conversion, average and cycle strobes come from the engine on CLK,
// and register accesses arrive already decoded from the serial interface
`timescale 1ns/1ps
`default_nettype none
module ocl_top (
  input  wire logic                    CLK,
  input  wire logic                    RST_N,
  input  wire logic [ocl_pkg::AW-1:0]  REG_ADDR,
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  input  wire logic [ocl_pkg::DW-1:0]  REG_WDATA,
  output var  logic [ocl_pkg::DW-1:0]  REG_RDATA,
  input  wire logic                    CONV_VALID,
  input  wire logic [1:0]              CONV_CHAN,
  input  wire logic [ocl_pkg::DW-1:0]  CONV_SHUNT,
  input  wire logic                    AVG_VALID,
  input  wire logic [1:0]              AVG_CHAN,
  input  wire logic [ocl_pkg::DW-1:0]  AVG_SHUNT,
  input  wire logic                    CYCLE_DONE,
  output var  logic [ocl_pkg::NCH-1:0] CRIT_FLAGS,
  output var  logic [ocl_pkg::NCH-1:0] WARN_FLAGS,
  output var  logic                    TOTAL_FLAG,
  output var  logic                    CRIT_ALERT,
  output var  logic                    WARN_ALERT
);
  import ocl_pkg::*;

  // limit or measurement field at the 40 uV weight, reserved bits dropped
  function automatic logic signed [LIM_W-1:0] lim_field(input logic [DW-1:0] r);
    return r[LIM_MSB:LIM_LSB];
  endfunction

  // channel 1 sits at the highest bit of each three-bit group of the mask register
  function automatic logic [NCH-1:0] ch_order(input logic [NCH-1:0] v);
    return {v[0], v[1], v[2]};
  endfunction

  // one-hot address hit to channel index; hits are one-hot, so no priority is needed
  function automatic int ch_index(input logic [NCH-1:0] hot);
    int idx;
    idx = 0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (hot[i]) begin
        idx = i;
      end
    end
    return idx;
  endfunction

  logic [DW-1:0]          crit_q [NCH];
  logic [DW-1:0]          warn_q [NCH];
  logic [DW-1:0]          tlim_q;
  logic [TOT_W-1:0]       total_q;
  logic [TOT_W-1:0]       total_d;
  logic [TOT_W-1:0]       acc_q;
  logic [TOT_W-1:0]       acc_d;
  logic [NCH-1:0]         sel_q;
  logic [NCH-1:0]         cf_q;
  logic [NCH-1:0]         cf_d;
  logic [NCH-1:0]         wf_q;
  logic [NCH-1:0]         wf_d;
  logic                   sf_q;
  logic                   sf_d;
  logic [DW-1:0]          rdata_q;
  logic                   crit_alert_q;
  logic                   warn_alert_q;
  logic [NCH-1:0]         crit_over;
  logic [NCH-1:0]         warn_over;
  logic [NCH-1:0]         wr_crit;
  logic [NCH-1:0]         wr_warn;
  logic [NCH-1:0]         hit_crit;
  logic [NCH-1:0]         hit_warn;
  logic [TOT_W-1:0]       conv_add;
  logic                   conv_sel;
  logic                   total_over;
  logic                   mask_rd;
  logic                   mask_wr;
  logic                   tlim_wr;
  logic                   hit_total;
  logic                   hit_tlim;
  logic                   hit_mask;
  logic [DW-1:0]          mask_view;
  logic [DW-1:0]          rd_mux;
  logic [DW-1:0]          rd_lim;
  logic signed [LIM_W-1:0] conv_f;
  logic signed [LIM_W-1:0] avg_f;

  assign conv_f = lim_field(CONV_SHUNT);
  assign avg_f  = lim_field(AVG_SHUNT);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // per-channel limit registers and their compares
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      assign wr_crit[ch]  = REG_WR && (REG_ADDR == ADDR_CRIT[ch]);
      assign wr_warn[ch]  = REG_WR && (REG_ADDR == ADDR_WARN[ch]);
      assign hit_crit[ch] = (REG_ADDR == ADDR_CRIT[ch]);
      assign hit_warn[ch] = (REG_ADDR == ADDR_WARN[ch]);
      // every single conversion, not the average, so short spikes are caught
      assign crit_over[ch] = CONV_VALID && (CONV_CHAN == 2'(ch))
                             && (conv_f > lim_field(crit_q[ch]));
      assign warn_over[ch] = AVG_VALID && (AVG_CHAN == 2'(ch))
                             && (avg_f > lim_field(warn_q[ch]));

      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          crit_q[ch] <= LIM_RST;
          warn_q[ch] <= LIM_RST;
        end else begin
          // reserved bits are stored but lim_field never looks at them
          if (wr_crit[ch]) begin
            crit_q[ch] <= REG_WDATA;
          end
          if (wr_warn[ch]) begin
            warn_q[ch] <= REG_WDATA;
          end
        end
      end
    end
  endgenerate

  // flags rise only with their own strobe, so a stray strobe cannot raise an alert
  a_crit_only_conv: assert property (
    (!CONV_VALID && CRIT_FLAGS == FLG_RST) |=> CRIT_FLAGS == FLG_RST)
    else $error("critical flag set without a conversion");

  a_warn_only_avg: assert property (
    (!AVG_VALID && WARN_FLAGS == FLG_RST) |=> WARN_FLAGS == FLG_RST)
    else $error("warning flag set without an average");

  a_crit_write: assert property (
    wr_crit[NCH-1] |=> crit_q[NCH-1] == $past(REG_WDATA))
    else $error("critical limit write lost");

  // summation of selected single conversions
  assign conv_sel = CONV_VALID && (CONV_CHAN != CH_NONE) && sel_q[CONV_CHAN];
  // both fields weigh 40 uV per bit, so the conversion lands unshifted in the sum
  assign conv_add = conv_sel ? {{(TOT_W-LIM_W){conv_f[LIM_W-1]}}, conv_f} : TOT_RST;
  // a conversion in the closing cycle still counts toward that cycle's sum
  assign acc_d    = acc_q + conv_add;
  assign total_d  = CYCLE_DONE ? acc_d : total_q;
  // signed compare of the fresh sum, bit 0 of the limit ignored
  assign total_over = CYCLE_DONE
                      && ($signed(acc_d) > $signed(tlim_q[TOT_MSB:TOT_LSB]));

  a_selected_add: assert property (
    (CONV_VALID && CONV_CHAN == 2'h1 && sel_q[1] && !CYCLE_DONE)
      |=> $signed(acc_q) == $signed($past(acc_q)) + $past(conv_f))
    else $error("selected conversion not added to the sum");

  // the running total restarts for every channel cycle
  a_acc_restart: assert property (
    CYCLE_DONE |=> acc_q == TOT_RST)
    else $error("running total not restarted at cycle end");

  a_sum_only_cycle: assert property (
    (!CYCLE_DONE && !TOTAL_FLAG) |=> !TOTAL_FLAG)
    else $error("sum flag set outside a cycle end");

  a_sum_no_false: assert property (
    (CYCLE_DONE && !TOTAL_FLAG
      && $signed(acc_d) <= $signed(tlim_q[TOT_MSB:TOT_LSB])) |=> !TOTAL_FLAG)
    else $error("sum flag set without excess");

  // mask register access; writes only reach the select bits
  assign hit_total = (REG_ADDR == ADDR_TOTAL);
  assign hit_tlim  = (REG_ADDR == ADDR_TLIM);
  assign hit_mask  = (REG_ADDR == ADDR_MASK);
  assign mask_rd   = REG_RD && hit_mask;
  assign mask_wr   = REG_WR && hit_mask;
  assign tlim_wr   = REG_WR && hit_tlim;

  // new events win over the read clear so nothing is lost in that cycle
  assign cf_d = (mask_rd ? FLG_RST : cf_q) | crit_over;
  assign wf_d = (mask_rd ? FLG_RST : wf_q) | warn_over;
  assign sf_d = (mask_rd ? 1'b0 : sf_q) | total_over;

  // only a mask read may take a flag down
  a_flags_sticky: assert property (
    !mask_rd |=> ({CRIT_FLAGS, WARN_FLAGS, TOTAL_FLAG}
      & $past({CRIT_FLAGS, WARN_FLAGS, TOTAL_FLAG}))
      == $past({CRIT_FLAGS, WARN_FLAGS, TOTAL_FLAG}))
    else $error("flag dropped without a mask read");

  a_mask_wr_keep: assert property (
    (mask_wr && !mask_rd && !CONV_VALID && !AVG_VALID && !CYCLE_DONE)
      |=> $stable(CRIT_FLAGS) && $stable(WARN_FLAGS) && $stable(TOTAL_FLAG))
    else $error("mask write changed a flag");

  // channel 1 at the top bit of each group; unimplemented mask bits read zero
  always_comb begin
    mask_view                 = ZERO_W;
    mask_view[SEL_LSB +: NCH] = ch_order(sel_q);
    mask_view[CF_LSB +: NCH]  = ch_order(cf_q);
    mask_view[SF_BIT]         = sf_q;
    mask_view[WF_LSB +: NCH]  = ch_order(wf_q);
  end

  assign rd_lim = (|hit_crit) ? crit_q[ch_index(hit_crit)]
                              : warn_q[ch_index(hit_warn)];
  // sum sits in 15:1 with bit 0 reading zero
  assign rd_mux = ((|hit_crit) || (|hit_warn)) ? rd_lim
                : hit_total                     ? {total_q, 1'b0}
                : hit_tlim                      ? tlim_q
                : hit_mask                      ? mask_view
                : ZERO_W;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      acc_q   <= TOT_RST;
      total_q <= TOT_RST;
    end else begin
      acc_q   <= CYCLE_DONE ? TOT_RST : acc_d;
      total_q <= total_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tlim_q <= TLIM_RST;
      sel_q  <= FLG_RST;
    end else begin
      if (tlim_wr) begin
        tlim_q <= REG_WDATA;
      end
      if (mask_wr) begin
        sel_q <= ch_order(REG_WDATA[SEL_LSB +: NCH]);
      end
    end
  end

  a_tlim_write: assert property (
    tlim_wr |=> tlim_q == $past(REG_WDATA))
    else $error("sum limit write lost");

  // channel 1 select sits at the top bit of the field
  a_select_write: assert property (
    mask_wr |=> sel_q[0] == $past(REG_WDATA[SEL_LSB + NCH - 1]))
    else $error("channel 1 summation select not taken");

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cf_q <= FLG_RST;
      wf_q <= FLG_RST;
      sf_q <= 1'b0;
    end else begin
      cf_q <= cf_d;
      wf_q <= wf_d;
      sf_q <= sf_d;
    end
  end

  // alerts follow the sticky flags, so they drop only after a mask read
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      crit_alert_q <= 1'b0;
      warn_alert_q <= 1'b0;
    end else begin
      crit_alert_q <= (|cf_d) || sf_d;
      warn_alert_q <= |wf_d;
    end
  end

  a_crit_alert_map: assert property (
    CRIT_ALERT == ((|CRIT_FLAGS) || TOTAL_FLAG))
    else $error("critical alert does not follow the flags");

  a_warn_alert_map: assert property (
    WARN_ALERT == (|WARN_FLAGS))
    else $error("warning alert does not follow the flags");

  // read data is taken on the strobe and held until the next read
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_q <= ZERO_W;
    end else if (REG_RD) begin
      rdata_q <= rd_mux;
    end
  end

  a_rd_hold: assert property (
    !REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");

  a_rd_unmapped: assert property (
    (REG_RD && (REG_ADDR < ADDR_CRIT[0] || REG_ADDR > ADDR_MASK))
      |=> REG_RDATA == ZERO_W)
    else $error("unmapped address did not read zero");

  assign REG_RDATA  = rdata_q;
  assign CRIT_FLAGS = cf_q;
  assign WARN_FLAGS = wf_q;
  assign TOTAL_FLAG = sf_q;
  assign CRIT_ALERT = crit_alert_q;
  assign WARN_ALERT = warn_alert_q;

  sequence s_mask_read;
    REG_RD && (REG_ADDR == ADDR_MASK);
  endsequence

  sequence s_quiet;
    !CONV_VALID && !AVG_VALID && !CYCLE_DONE;
  endsequence

  a_crit_flag_set: assert property (
    (CONV_VALID && CONV_CHAN == 2'h0 && conv_f > lim_field(crit_q[0]))
      |=> CRIT_FLAGS[0] && CRIT_ALERT)
    else $error("critical excess on channel 1 not flagged");

  a_warn_flag_set: assert property (
    (AVG_VALID && AVG_CHAN == 2'h2 && avg_f > lim_field(warn_q[2]))
      |=> WARN_FLAGS[2] && WARN_ALERT)
    else $error("warning excess on channel 3 not flagged");

  a_crit_no_false: assert property (
    (CONV_VALID && CONV_CHAN == 2'h1 && conv_f <= lim_field(crit_q[1])
      && !CRIT_FLAGS[1]) |=> !CRIT_FLAGS[1])
    else $error("critical flag set without excess");

  a_limit_reset: assert property (
    !$past(RST_N) |-> crit_q[0] == LIM_RST && warn_q[2] == LIM_RST
      && tlim_q == TLIM_RST && total_q == TOT_RST)
    else $error("limit or sum reset value wrong");

  a_limit_readback: assert property (
    (REG_WR && REG_ADDR == ADDR_WARN[1]) ##1 (REG_RD && REG_ADDR == ADDR_WARN[1]
      && !REG_WR) |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("warning limit did not read back");

  a_total_hold: assert property (
    !CYCLE_DONE |=> $stable(total_q))
    else $error("sum changed outside a cycle end");

  a_sum_flag: assert property (
    (CYCLE_DONE && $signed(acc_d) > $signed(tlim_q[TOT_MSB:TOT_LSB]))
      |=> TOTAL_FLAG && CRIT_ALERT && total_q == $past(acc_d))
    else $error("sum excess not flagged");

  a_unselected_skip: assert property (
    (CONV_VALID && CONV_CHAN != CH_NONE && !sel_q[CONV_CHAN] && !CYCLE_DONE)
      |=> acc_q == $past(acc_q))
    else $error("unselected channel added to sum");

  a_flag_clear: assert property (
    (s_mask_read and s_quiet) |=> CRIT_FLAGS == FLG_RST && !TOTAL_FLAG
      && WARN_FLAGS == FLG_RST)
    else $error("flags not cleared by mask read");

  a_total_bit0: assert property (
    (REG_RD && REG_ADDR == ADDR_TOTAL) |=> !REG_RDATA[0]
      && REG_RDATA[TOT_MSB:TOT_LSB] == $past(total_q))
    else $error("sum read format wrong");
endmodule
`default_nettype wire

// ---- overcurrent_limit_and_sum_compare_bench.sv ----
// self-checking bench: random measurement strobes and register traffic against a model
// assumes the design registers every result on the sampling edge itself
`timescale 1ns/1ps
`default_nettype none
module overcurrent_limit_and_sum_compare_bench;
  import ocl_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, conv_valid, avg_valid, cycle_done;
  logic crit_alert, warn_alert, total_flag;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, conv_shunt, avg_shunt, rd_m, tlim;
  logic [1:0] conv_chan, avg_chan;
  logic [2:0] crit_flags, warn_flags, cf, wf, selm;
  logic [DW-1:0] lim_c [3];
  logic [DW-1:0] lim_w [3];
  logic sf;
  int acc, tot, fail_count, cmp_count, cyc, seed;
  logic [31:0] r;
  ocl_top ocl_top_inst (.CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .CONV_VALID(conv_valid),
    .CONV_CHAN(conv_chan), .CONV_SHUNT(conv_shunt), .AVG_VALID(avg_valid), .AVG_CHAN(avg_chan),
    .AVG_SHUNT(avg_shunt), .CYCLE_DONE(cycle_done), .CRIT_FLAGS(crit_flags),
    .WARN_FLAGS(warn_flags), .TOTAL_FLAG(total_flag), .CRIT_ALERT(crit_alert),
    .WARN_ALERT(warn_alert));
  ocl_host ocl_host_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic int f13(input logic [DW-1:0] v);
    return $signed(v[15:3]);
  endfunction
  function automatic int w15(input int x);
    logic signed [14:0] t;
    t = x[14:0];
    return t;
  endfunction
  function automatic logic [DW-1:0] view(input logic [AW-1:0] a);
    if (a >= 8'h07 && a <= 8'h0c)
      return ((a - 8'h07) % 2 == 0) ? lim_c[(a - 8'h07) / 2] : lim_w[(a - 8'h07) / 2];
    if (a == 8'h0d)
      return {tot[14:0], 1'b0};
    if (a == 8'h0e)
      return tlim;
    if (a == 8'h0f)
      return {1'b0, selm, 2'b00, cf[0], cf[1], cf[2], sf, wf[0], wf[1], wf[2], 3'b000};
    return 16'h0000;
  endfunction
  // model of the block, updated on the same edge the design samples
  always @(posedge clk) begin
    if (!rst_n) begin
      foreach (lim_c[i]) begin
        lim_c[i] = 16'h7ff8;
        lim_w[i] = 16'h7ff8;
      end
      tlim = 16'h7ffe;
      {acc, tot, selm, cf, wf, sf, rd_m} = '0;
    end else begin
      if (reg_rd) rd_m = view(reg_addr);
      if (reg_rd && reg_addr == 8'h0f) {cf, wf, sf} = '0;
      if (conv_valid && conv_chan < 2'h3) begin
        if (f13(conv_shunt) > f13(lim_c[conv_chan])) cf[conv_chan] = 1'b1;
        if (selm[2 - conv_chan]) acc = acc + f13(conv_shunt);
      end
      if (avg_valid && avg_chan < 2'h3 && f13(avg_shunt) > f13(lim_w[avg_chan]))
        wf[avg_chan] = 1'b1;
      if (cycle_done) begin
        tot = w15(acc);
        acc = 0;
        if (tot > w15(tlim[15:1])) sf = 1'b1;
      end
      if (reg_wr && reg_addr >= 8'h07 && reg_addr <= 8'h0c) begin
        if ((reg_addr - 8'h07) % 2 == 0) lim_c[(reg_addr - 8'h07) / 2] = reg_wdata;
        else lim_w[(reg_addr - 8'h07) / 2] = reg_wdata;
      end
      if (reg_wr && reg_addr == 8'h0e) tlim = reg_wdata;
      if (reg_wr && reg_addr == 8'h0f) selm = reg_wdata[14:12];
    end
  end
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(negedge clk) begin
    if (rst_n) begin
      check({7'h00, crit_flags, warn_flags, total_flag, crit_alert, warn_alert},
            {7'h00, cf, wf, sf, (|cf) | sf, |wf});
      check(reg_rdata, rd_m);
    end
  end
  task automatic end_sim;
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // a long stall means a hung bench; ceiling well above the planned traffic
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic quiet;
    conv_valid = 1'b0;
    avg_valid = 1'b0;
    cycle_done = 1'b0;
  endtask
  task automatic reg_op(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    #1;
    quiet();
    ocl_host_inst.access(wr, a, d);
  endtask
  initial begin
    seed = 94458;
    rst_n = 1'b0;
    {conv_chan, avg_chan, conv_shunt, avg_shunt} = '0;
    quiet();
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int a = 6; a <= 16; a++) reg_op(1'b0, a[7:0], 16'h0000);
    for (int i = 0; i < 700; i++) begin
      r = $random(seed);
      if (r[2:0] == 3'h0) reg_op(1'b1, 8'h07 + 8'(r[11:8] % 9), 16'($random(seed)));
      else if (r[2:0] < 3'h3) reg_op(1'b0, 8'h06 + 8'(r[11:8] % 11), 16'h0000);
      else begin
        @(posedge clk);
        #1;
        conv_valid = r[3];
        conv_chan = r[5:4];
        conv_shunt = 16'($random(seed));
        avg_valid = r[6];
        avg_chan = r[13:12];
        avg_shunt = 16'($random(seed));
        cycle_done = (r[18:16] == 3'h0);
      end
    end
    // back-to-back write and read of one limit, then a reset in mid-run
    repeat (4) begin
      @(posedge clk);
      #1;
      quiet();
      ocl_host_inst.wr_rd(ADDR_WARN[1], 16'($random(seed)));
    end
    @(posedge clk);
    #1;
    quiet();
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int a = 6; a <= 16; a++) reg_op(1'b0, a[7:0], 16'h0000);
    reg_op(1'b1, 8'h20, 16'hffff);
    reg_op(1'b0, 8'h20, 16'h0000);
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule
`default_nettype wire
